// ==== hw/dpf_pkg.sv ====
package dpf_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_TX_PAGE_START = 8'h00;
   localparam logic [7:0] OFS_TX_LENGTH_LOW = 8'h04;
   localparam logic [7:0] OFS_TX_LENGTH_HIGH = 8'h08;
   localparam logic [7:0] OFS_RX_RING_FIRST_PAGE = 8'h0c;
   localparam logic [7:0] OFS_RX_RING_LAST_PAGE = 8'h10;
   localparam logic [7:0] OFS_RX_READ_POINTER = 8'h14;
   localparam logic [7:0] OFS_RX_WRITE_PAGE = 8'h18;
   localparam logic [7:0] OFS_LOCAL_DMA_ADDR_LOW = 8'h1c;
   localparam logic [7:0] OFS_LOCAL_DMA_ADDR_HIGH = 8'h20;
   localparam logic [7:0] OFS_REMOTE_START_LOW = 8'h24;
   localparam logic [7:0] OFS_REMOTE_START_HIGH = 8'h28;
   localparam logic [7:0] OFS_REMOTE_COUNT_LOW = 8'h2c;
   localparam logic [7:0] OFS_REMOTE_COUNT_HIGH = 8'h30;
   localparam logic [7:0] OFS_REMOTE_ADDR_NOW_LOW = 8'h34;
   localparam logic [7:0] OFS_REMOTE_ADDR_NOW_HIGH = 8'h38;
   localparam logic [7:0] OFS_CONTROL = 8'h3c;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   // station address bytes 0..5 at 0x44 + 4*i, group filters 0..7 at 0x60 + 4*i
   localparam logic [7:0] OFS_STATION_BASE = 8'h44;
   localparam logic [7:0] OFS_GROUP_BASE = 8'h60;
   // control register bits
   localparam int CTL_TX_GO = 0;
   localparam int CTL_RDMA_GO = 1;
   localparam int CTL_RDMA_WORD = 2;
   localparam int CTL_PROMISC = 3;
   // status register bits
   localparam int STS_TX_BUSY = 0;
   localparam int STS_RDMA_BUSY = 1;
   localparam int STS_RX_ABORT = 2;
   localparam int STS_ACCEPT = 3;
   localparam int STS_MCAST = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'h04c11db7;
   localparam int DEST_BITS = 48;
   typedef enum logic [1:0] {DPF_RX_IDLE, DPF_RX_ADDR, DPF_RX_DATA} dpf_rx_state_t;
endpackage

// ==== hw/dpf_top.sv ====
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
// Functional notes
// - transmit start loads page into address high byte, low byte zero.
// - full programmed byte count is sent; nothing truncated above 1500.
// - transmit length split: high register bits 15..8, low bits 7..0.
// - ring first and last page registers hold address bits 15..8 only.
// - next receive page equal to read pointer aborts local dma.
// - write page holds first buffer of packet; restores pointer on error.
// - live local dma address readable as high and low bytes.
// - remote dma starts at start address and moves count bytes.
// - remote start and count registers supply low and high bytes.
// - each remote transfer advances address and reduces count by two or one.
// - present remote address readable as high and low bytes, live.
// - destination compared against six station bytes, bit by bit.
// - station byte 0 matches destination bits 7..0, byte 5 bits 47..40.
// - first destination bit received marks physical or multicast.
// - destination through crc; top six crc bits latched at last bit.
// - latched hash picks one of 64 filter bits; set bit accepts multicast.
// - receive page reaching ring last page wraps to ring first page.
// - crc uses the standard 32-bit ethernet polynomial.
module dpf_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // local dma: transmit byte strobe and receive stream, same clock
   input wire logic tx_byte_done,
   input wire logic rx_start,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_byte_done,
   input wire logic rx_error,
   input wire logic rx_end,
   // remote dma transfer strobe
   input wire logic rdma_xfer,
   // buffer memory address and status outputs
   output logic [15:0] local_addr,
   output logic [15:0] remote_addr,
   output logic tx_active,
   output logic rdma_active,
   output logic addr_accept,
   output logic addr_done
);
   logic [7:0] tx_page_start, tx_length_low, tx_length_high;
   logic [7:0] rx_ring_first_page, rx_ring_last_page, rx_read_pointer, rx_write_page;
   logic [7:0] remote_start_low, remote_start_high, remote_count_low, remote_count_high;
   logic [7:0] station_addr [6];
   logic [7:0] group_filter [8];
   logic [7:0] control;
   logic [15:0] tx_left, rdma_left;
   logic rx_abort;
   dpf_pkg::dpf_rx_state_t rx_state;
   logic [5:0] bit_cnt;
   logic [31:0] crc;
   logic [5:0] hash;
   logic dest_first_bit, station_ok, accept_q, mcast_q;
   logic wr_en, rd_en;
   logic [7:0] status;
   logic [31:0] next_crc;
   logic [7:0] next_page;

   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign tx_active = (tx_left != 16'h0000);
   assign rdma_active = (rdma_left != 16'h0000);
   assign addr_accept = accept_q;

   // writable byte registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_page_start <= dpf_pkg::RESET_BYTE;
         tx_length_low <= dpf_pkg::RESET_BYTE;
         tx_length_high <= dpf_pkg::RESET_BYTE;
         rx_ring_first_page <= dpf_pkg::RESET_BYTE;
         rx_ring_last_page <= dpf_pkg::RESET_BYTE;
         rx_read_pointer <= dpf_pkg::RESET_BYTE;
         remote_start_low <= dpf_pkg::RESET_BYTE;
         remote_start_high <= dpf_pkg::RESET_BYTE;
         remote_count_low <= dpf_pkg::RESET_BYTE;
         remote_count_high <= dpf_pkg::RESET_BYTE;
         control <= dpf_pkg::RESET_BYTE;
      end else begin
         // go bits are self-clearing so a write starts at most one run; transmit go is ignored while tx_active
         control[dpf_pkg::CTL_TX_GO] <= 1'b0;
         control[dpf_pkg::CTL_RDMA_GO] <= 1'b0;
         if (wr_en) begin
            case (paddr)
               dpf_pkg::OFS_TX_PAGE_START: tx_page_start <= pwdata[7:0];
               dpf_pkg::OFS_TX_LENGTH_LOW: tx_length_low <= pwdata[7:0];
               dpf_pkg::OFS_TX_LENGTH_HIGH: tx_length_high <= pwdata[7:0];
               dpf_pkg::OFS_RX_RING_FIRST_PAGE: rx_ring_first_page <= pwdata[7:0];
               dpf_pkg::OFS_RX_RING_LAST_PAGE: rx_ring_last_page <= pwdata[7:0];
               dpf_pkg::OFS_RX_READ_POINTER: rx_read_pointer <= pwdata[7:0];
               dpf_pkg::OFS_REMOTE_START_LOW: remote_start_low <= pwdata[7:0];
               dpf_pkg::OFS_REMOTE_START_HIGH: remote_start_high <= pwdata[7:0];
               dpf_pkg::OFS_REMOTE_COUNT_LOW: remote_count_low <= pwdata[7:0];
               dpf_pkg::OFS_REMOTE_COUNT_HIGH: remote_count_high <= pwdata[7:0];
               dpf_pkg::OFS_CONTROL: control <= pwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // station and group filter arrays
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_filt
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               group_filter[gi] <= dpf_pkg::RESET_BYTE;
            end else if (wr_en && paddr == dpf_pkg::OFS_GROUP_BASE + 8'(4 * gi)) begin
               group_filter[gi] <= pwdata[7:0];
            end
         end
         if (gi < 6) begin : g_sta
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  station_addr[gi] <= dpf_pkg::RESET_BYTE;
               end else if (wr_en && paddr == dpf_pkg::OFS_STATION_BASE + 8'(4 * gi)) begin
                  station_addr[gi] <= pwdata[7:0];
               end
            end
         end
      end
   endgenerate

   // transmit local dma
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_left <= 16'h0000;
      end else if (control[dpf_pkg::CTL_TX_GO] && !tx_active) begin
         tx_left <= {tx_length_high, tx_length_low};
      end else if (tx_active && tx_byte_done) begin
         tx_left <= tx_left - 16'h0001;
      end
   end

   // next receive page with ring wrap
   always_comb begin
      if (local_addr[15:8] + 8'h01 == rx_ring_last_page) begin
         next_page = rx_ring_first_page;
      end else begin
         next_page = local_addr[15:8] + 8'h01;
      end
   end

   // local dma address, shared by transmit and receive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_addr <= 16'h0000;
         rx_abort <= 1'b0;
      end else if (control[dpf_pkg::CTL_TX_GO] && !tx_active) begin
         local_addr <= {tx_page_start, 8'h00};
      end else if (tx_active && tx_byte_done) begin
         local_addr <= local_addr + 16'h0001;
      end else if (rx_start) begin
         local_addr <= {rx_write_page, 8'h00};
         rx_abort <= 1'b0;
      end else if (rx_error) begin
         local_addr <= {rx_write_page, 8'h00};
      end else if (rx_byte_done && !rx_abort) begin
         if (local_addr[7:0] == 8'hff) begin
            if (next_page == rx_read_pointer) begin
               rx_abort <= 1'b1;
            end else begin
               local_addr <= {next_page, 8'h00};
            end
         end else begin
            local_addr <= local_addr + 16'h0001;
         end
      end
   end

   // write page advances past a good packet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_write_page <= dpf_pkg::RESET_BYTE;
      end else if (wr_en && paddr == dpf_pkg::OFS_RX_WRITE_PAGE) begin
         rx_write_page <= pwdata[7:0];
      end else if (rx_end && !rx_abort && !rx_error) begin
         rx_write_page <= next_page;
      end
   end

   // remote dma
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote_addr <= 16'h0000;
         rdma_left <= 16'h0000;
      end else if (control[dpf_pkg::CTL_RDMA_GO]) begin
         remote_addr <= {remote_start_high, remote_start_low};
         rdma_left <= {remote_count_high, remote_count_low};
      end else if (rdma_active && rdma_xfer) begin
         if (control[dpf_pkg::CTL_RDMA_WORD] && rdma_left > 16'h0001) begin
            remote_addr <= remote_addr + 16'h0002;
            rdma_left <= rdma_left - 16'h0002;
         end else begin
            remote_addr <= remote_addr + 16'h0001;
            rdma_left <= rdma_left - 16'h0001;
         end
      end
   end

   always_comb begin
      next_crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ rx_bit) ? dpf_pkg::CRC_POLY : 32'h00000000);
   end

   // destination address filter, bit serial
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= dpf_pkg::DPF_RX_IDLE;
         bit_cnt <= 6'h00;
         crc <= dpf_pkg::CRC_INIT;
         hash <= 6'h00;
         dest_first_bit <= 1'b0;
         station_ok <= 1'b0;
         accept_q <= 1'b0;
         mcast_q <= 1'b0;
         addr_done <= 1'b0;
      end else begin
         addr_done <= 1'b0;
         case (rx_state)
            dpf_pkg::DPF_RX_IDLE: begin
               if (rx_start) begin
                  rx_state <= dpf_pkg::DPF_RX_ADDR;
                  bit_cnt <= 6'h00;
                  crc <= dpf_pkg::CRC_INIT;
                  station_ok <= 1'b1;
                  accept_q <= 1'b0;
               end
            end
            dpf_pkg::DPF_RX_ADDR: begin
               if (rx_bit_valid) begin
                  crc <= next_crc;
                  bit_cnt <= bit_cnt + 6'h01;
                  if (rx_bit != station_addr[bit_cnt[5:3]][bit_cnt[2:0]]) begin
                     station_ok <= 1'b0;
                  end
                  if (bit_cnt == 6'h00) begin
                     dest_first_bit <= rx_bit;
                  end
                  if (bit_cnt == 6'(dpf_pkg::DEST_BITS - 1)) begin
                     hash <= next_crc[31:26];
                     addr_done <= 1'b1;
                     mcast_q <= dest_first_bit;
                     accept_q <= control[dpf_pkg::CTL_PROMISC] | (dest_first_bit ?
                        group_filter[next_crc[31:29]][next_crc[28:26]] :
                        (station_ok && rx_bit == station_addr[5][7]));
                     rx_state <= dpf_pkg::DPF_RX_DATA;
                  end
               end
            end
            dpf_pkg::DPF_RX_DATA: begin
               if (rx_end || rx_error) begin
                  rx_state <= dpf_pkg::DPF_RX_IDLE;
               end
            end
            default: rx_state <= dpf_pkg::DPF_RX_IDLE;
         endcase
      end
   end

   assign status = {3'b000, mcast_q, accept_q, rx_abort, rdma_active, tx_active};

   // read mux
   always_comb begin
      prdata = 32'h00000000;
      pslverr = 1'b0;
      if (rd_en) begin
         case (paddr)
            dpf_pkg::OFS_TX_PAGE_START: prdata[7:0] = tx_page_start;
            dpf_pkg::OFS_TX_LENGTH_LOW: prdata[7:0] = tx_length_low;
            dpf_pkg::OFS_TX_LENGTH_HIGH: prdata[7:0] = tx_length_high;
            dpf_pkg::OFS_RX_RING_FIRST_PAGE: prdata[7:0] = rx_ring_first_page;
            dpf_pkg::OFS_RX_RING_LAST_PAGE: prdata[7:0] = rx_ring_last_page;
            dpf_pkg::OFS_RX_READ_POINTER: prdata[7:0] = rx_read_pointer;
            dpf_pkg::OFS_RX_WRITE_PAGE: prdata[7:0] = rx_write_page;
            dpf_pkg::OFS_LOCAL_DMA_ADDR_LOW: prdata[7:0] = local_addr[7:0];
            dpf_pkg::OFS_LOCAL_DMA_ADDR_HIGH: prdata[7:0] = local_addr[15:8];
            dpf_pkg::OFS_REMOTE_START_LOW: prdata[7:0] = remote_start_low;
            dpf_pkg::OFS_REMOTE_START_HIGH: prdata[7:0] = remote_start_high;
            dpf_pkg::OFS_REMOTE_COUNT_LOW: prdata[7:0] = remote_count_low;
            dpf_pkg::OFS_REMOTE_COUNT_HIGH: prdata[7:0] = remote_count_high;
            dpf_pkg::OFS_REMOTE_ADDR_NOW_LOW: prdata[7:0] = remote_addr[7:0];
            dpf_pkg::OFS_REMOTE_ADDR_NOW_HIGH: prdata[7:0] = remote_addr[15:8];
            dpf_pkg::OFS_CONTROL: prdata[7:0] = control;
            dpf_pkg::OFS_STATUS: prdata[7:0] = status;
            default: begin
               if (paddr >= dpf_pkg::OFS_STATION_BASE && paddr < dpf_pkg::OFS_GROUP_BASE - 8'h04
                   && paddr[1:0] == 2'b00) begin
                  prdata[7:0] = station_addr[3'((paddr - dpf_pkg::OFS_STATION_BASE) >> 2)];
               end else if (paddr >= dpf_pkg::OFS_GROUP_BASE && paddr < 8'h80
                   && paddr[1:0] == 2'b00) begin
                  prdata[7:0] = group_filter[3'((paddr - dpf_pkg::OFS_GROUP_BASE) >> 2)];
               end else begin
                  pslverr = 1'b1;
               end
            end
         endcase
      end
   end

   a_tx_addr_load: assert property (@(posedge pclk) disable iff (!presetn)
      control[dpf_pkg::CTL_TX_GO] && !tx_active |=> local_addr == {$past(tx_page_start), 8'h00})
      else $error("transmit start address wrong");
   a_tx_full_count: assert property (@(posedge pclk) disable iff (!presetn)
      control[dpf_pkg::CTL_TX_GO] && !tx_active |=>
      tx_left == {$past(tx_length_high), $past(tx_length_low)})
      else $error("transmit count not loaded");
   a_rdma_load: assert property (@(posedge pclk) disable iff (!presetn)
      control[dpf_pkg::CTL_RDMA_GO] |=> remote_addr == {$past(remote_start_high),
      $past(remote_start_low)})
      else $error("remote start not loaded");
   a_rdma_byte_step: assert property (@(posedge pclk) disable iff (!presetn)
      rdma_active && rdma_xfer && !control[dpf_pkg::CTL_RDMA_GO]
      && !control[dpf_pkg::CTL_RDMA_WORD] |=> remote_addr == $past(remote_addr) + 16'h0001)
      else $error("remote byte step wrong");
   a_rdma_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !rdma_active && !control[dpf_pkg::CTL_RDMA_GO] |=> $stable(remote_addr))
      else $error("remote address moved while idle");
   a_rx_abort_hit: assert property (@(posedge pclk) disable iff (!presetn)
      rx_byte_done && !rx_abort && !rx_start && !rx_error && !tx_active
      && !control[dpf_pkg::CTL_TX_GO] && local_addr[7:0] == 8'hff
      && next_page == rx_read_pointer |=> rx_abort)
      else $error("boundary not caught");
   a_ring_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      rx_byte_done && !rx_abort && !rx_start && !rx_error && !tx_active
      && !control[dpf_pkg::CTL_TX_GO] && local_addr[7:0] == 8'hff
      && local_addr[15:8] + 8'h01 == rx_ring_last_page && rx_ring_first_page != rx_read_pointer
      |=> local_addr == {$past(rx_ring_first_page), 8'h00})
      else $error("ring did not wrap");
   a_hash_latch: assert property (@(posedge pclk) disable iff (!presetn)
      addr_done |-> hash == $past(next_crc[31:26]))
      else $error("hash not latched");
endmodule // dpf_top

// ==== tb/dpf_far_model.sv ====
`timescale 1ns/1ns
// far side of the receive path: the decoder handing destination bits over
module dpf_far_model (
   // clock
   input wire logic pclk,
   // receive stream
   output logic rx_start,
   output logic rx_bit_valid,
   output logic rx_bit
);
   initial begin
      rx_start = 1'b0;
      rx_bit_valid = 1'b0;
      rx_bit = 1'b1;
   end

   task automatic send(input logic [47:0] d);
      @(posedge pclk);
      rx_start <= 1'b1;
      @(posedge pclk);
      rx_start <= 1'b0;
      for (int i = 0; i < 48; i++) begin
         rx_bit_valid <= 1'b1;
         rx_bit <= d[i];
         @(posedge pclk);
      end
      // released line shows the inverse so stale data never looks valid
      rx_bit_valid <= 1'b0;
      rx_bit <= ~d[47];
   endtask
endmodule // dpf_far_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] strb = 5'h00;
   logic [31:0] prdata, rd_v, wd;
   logic pready, pslverr, err_v, rx_start, rx_bit_valid, rx_bit;
   logic tx_active, rdma_active, addr_accept, addr_done;
   logic [15:0] local_addr, remote_addr, a0;
   logic [47:0] st, d;
   logic [5:0] h;
   logic [7:0] v, ga;
   int seed = 86;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;

   always #20 pclk = ~pclk;

   dpf_far_model far (.pclk(pclk), .rx_start(rx_start), .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit));

   dpf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_byte_done(strb[0]), .rx_start(rx_start),
      .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_byte_done(strb[1]),
      .rx_error(strb[2]), .rx_end(strb[3]), .rdma_xfer(strb[4]), .local_addr(local_addr),
      .remote_addr(remote_addr), .tx_active(tx_active), .rdma_active(rdma_active),
      .addr_accept(addr_accept), .addr_done(addr_done));

   task automatic stop_test();
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] x);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= x;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      apb(1'b1, a, x);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // strobe held high for cnt edges back to back
   task automatic pulse(input int b, input int cnt);
      @(posedge pclk);
      strb[b] <= 1'b1;
      repeat (cnt) @(posedge pclk);
      strb[b] <= 1'b0;
      #1;
   endtask

   task automatic frame(input logic [47:0] dd, input logic exp);
      int k;
      far.send(dd);
      // the done pulse stands for one cycle from the edge that takes the last bit
      k = 0;
      #1;
      while (addr_done !== 1'b1 && k < 8) begin
         @(posedge pclk);
         #1;
         k++;
      end
      chk(32'(addr_done), 32'h1);
      chk(32'(addr_accept), 32'(exp));
      // close the frame so the filter is idle for the next rx_start
      pulse(2, 1);
   endtask

   function automatic logic [5:0] hash_of(input logic [47:0] dd);
      logic [31:0] c;
      c = dpf_pkg::CRC_INIT;
      for (int i = 0; i < 48; i++) begin
         c = {c[30:0], 1'b0} ^ ((c[31] ^ dd[i]) ? dpf_pkg::CRC_POLY : 32'h0);
      end
      return c[31:26];
   endfunction

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 'h84; a += 4) begin
         rd(8'(a));
         chk(32'(err_v), 32'(a == 'h5c || a == 'h80));
         if (a != 'h5c && a != 'h80) chk(rd_v, 32'h0);
      end
      for (int a = 0; a < 'h80; a += 4) begin
         wd = $random(seed);
         // keep go and promiscuous bits clear so no run starts here
         if (a == 'h3c) wd = wd & 32'h4;
         wr(8'(a), wd);
         rd(8'(a));
         if (a inside {'h1c, 'h20, 'h34, 'h38, 'h40, 'h5c}) continue;
         chk(rd_v, {24'h0, wd[7:0]});
      end
      rd(dpf_pkg::OFS_LOCAL_DMA_ADDR_LOW);
      chk(rd_v, 32'h0);
      v = $random(seed);
      wr(dpf_pkg::OFS_TX_PAGE_START, {24'h0, v});
      wr(dpf_pkg::OFS_TX_LENGTH_LOW, 32'hde);
      wr(dpf_pkg::OFS_TX_LENGTH_HIGH, 32'h05);
      wr(dpf_pkg::OFS_CONTROL, 32'h1 << dpf_pkg::CTL_TX_GO);
      rd(dpf_pkg::OFS_LOCAL_DMA_ADDR_HIGH);
      chk(rd_v, {24'h0, v});
      rd(dpf_pkg::OFS_LOCAL_DMA_ADDR_LOW);
      chk(rd_v, 32'h0);
      pulse(0, 1501);
      chk(32'(tx_active), 32'h1);
      pulse(0, 1);
      a0 = {v, 8'h00} + 16'd1502;
      chk(32'(local_addr), 32'(a0));
      chk(32'(tx_active), 32'h0);
      rd(dpf_pkg::OFS_LOCAL_DMA_ADDR_LOW);
      chk(rd_v, {24'h0, a0[7:0]});
      for (int m = 0; m < 2; m++) begin
         a0 = $random(seed);
         n = m ? 261 : 1 + $unsigned($random(seed)) % 6;
         wr(dpf_pkg::OFS_REMOTE_START_LOW, {24'h0, a0[7:0]});
         wr(dpf_pkg::OFS_REMOTE_START_HIGH, {24'h0, a0[15:8]});
         wr(dpf_pkg::OFS_REMOTE_COUNT_LOW, {24'h0, n[7:0]});
         wr(dpf_pkg::OFS_REMOTE_COUNT_HIGH, {24'h0, n[15:8]});
         wr(dpf_pkg::OFS_CONTROL, (32'h1 << dpf_pkg::CTL_RDMA_GO) | (m << dpf_pkg::CTL_RDMA_WORD));
         rd(dpf_pkg::OFS_REMOTE_ADDR_NOW_HIGH);
         chk(rd_v, {24'h0, a0[15:8]});
         chk(32'(rdma_active), 32'h1);
         pulse(4, n + 1);
         a0 = a0 + n[15:0];
         chk(32'(remote_addr), 32'(a0));
         chk(32'(rdma_active), 32'h0);
         rd(dpf_pkg::OFS_REMOTE_ADDR_NOW_LOW);
         chk(rd_v, {24'h0, a0[7:0]});
      end
      st = {16'($random(seed)), 32'($random(seed))};
      st[0] = 1'b0;
      for (int k = 0; k < 6; k++) wr(dpf_pkg::OFS_STATION_BASE + 8'(4 * k), {24'h0, st[8*k+:8]});
      frame(st, 1'b1);
      rd(dpf_pkg::OFS_STATUS);
      chk(32'(rd_v[dpf_pkg::STS_MCAST]), 32'h0);
      chk(32'(rd_v[dpf_pkg::STS_ACCEPT]), 32'h1);
      for (int i = 0; i < 4; i++) begin
         d = st;
         n = (i == 0) ? 47 : 1 + $unsigned($random(seed)) % 47;
         d[n] = ~d[n];
         frame(d, 1'b0);
      end
      // promiscuous mode takes a frame that matches nothing
      wr(dpf_pkg::OFS_CONTROL, 32'h1 << dpf_pkg::CTL_PROMISC);
      frame(d, 1'b1);
      wr(dpf_pkg::OFS_CONTROL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         d = {16'($random(seed)), 32'($random(seed))};
         d[0] = 1'b1;
         h = hash_of(d);
         ga = dpf_pkg::OFS_GROUP_BASE + 8'(4 * h[5:3]);
         for (int g = 0; g < 8; g++) wr(dpf_pkg::OFS_GROUP_BASE + 8'(4 * g), 32'h0);
         wr(ga, 32'h1 << h[2:0]);
         frame(d, 1'b1);
         wr(ga, 32'hff & ~(32'h1 << h[2:0]));
         frame(d, 1'b0);
      end
      for (int g = 0; g < 8; g++) wr(dpf_pkg::OFS_GROUP_BASE + 8'(4 * g), 32'hff);
      frame(48'hffff_ffff_ffff, 1'b1);
      rd(dpf_pkg::OFS_STATUS);
      chk(32'(rd_v[dpf_pkg::STS_MCAST]), 32'h1);
      wr(dpf_pkg::OFS_RX_RING_FIRST_PAGE, 32'h40);
      wr(dpf_pkg::OFS_RX_RING_LAST_PAGE, 32'h42);
      wr(dpf_pkg::OFS_RX_WRITE_PAGE, 32'h40);
      wr(dpf_pkg::OFS_RX_READ_POINTER, 32'h50);
      frame(st, 1'b1);
      chk(32'(local_addr), 32'h4000);
      pulse(1, 256);
      chk(32'(local_addr), 32'h4100);
      pulse(2, 1);
      chk(32'(local_addr), 32'h4000);
      pulse(1, 512);
      chk(32'(local_addr), 32'h4000);
      // a good end moves the write page one page on
      pulse(3, 1);
      rd(dpf_pkg::OFS_RX_WRITE_PAGE);
      chk(rd_v, 32'h41);
      rd(dpf_pkg::OFS_STATUS);
      chk(32'(rd_v[dpf_pkg::STS_RX_ABORT]), 32'h0);
      wr(dpf_pkg::OFS_RX_READ_POINTER, 32'h40);
      frame(st, 1'b1);
      pulse(1, 256);
      rd(dpf_pkg::OFS_STATUS);
      chk(32'(rd_v[dpf_pkg::STS_RX_ABORT]), 32'h1);
      // an aborted packet must not move the write page
      pulse(3, 1);
      rd(dpf_pkg::OFS_RX_WRITE_PAGE);
      chk(rd_v, 32'h41);
      stop_test();
   end
endmodule // tb_top
